/* core/dcc_top.sv */
// dual comparator control and status top level
// Functional notes
// - Setting a comparator's enable bit turns it on, clearing it shuts it down.
// - A disabled comparator drives its pin output low and raises no interrupt.
// - Interrupts can come from both rising and falling output transitions.
// - A falling edge sets the fall flag and a rising edge sets the rise flag.
// - Flags stay set until software clears them by writing zero.
// - The output level is readable at any time in a read-only status bit.
// - Comparator 0 may be chosen as a reset source, comparator 1 may not.
// - The low four bits of each control register hold the hysteresis fields.
// - Each hysteresis field selects off, 2, 4 or 10 mV independently.
// - Comparator 1 mirrors comparator 0 with its own control register.
// - The output serves as a polled level or as an interrupt source.
`timescale 1ns/100ps
`include "dcc_defines.svh"
module dcc_top
  import dcc_pkg::*;
#(
  parameter int SETTLE_CYC = `DCC_SETTLE_CYC
)(
  input  wire logic                   I_CLK,
  input  wire logic                   I_SRST,
  input  wire logic [`DCC_ADDR_W-1:0] I_ADDR,
  input  wire logic [7:0]             I_WDATA,
  input  wire logic                   I_WR,
  input  wire logic                   I_RD,
  input  wire logic [1:0]             I_CMP_RAW,
  output logic      [7:0]             O_RDATA,
  output logic      [1:0]             O_CMP_PIN,
  output logic      [1:0]             O_SETTLED,
  output dcc_pkg::dcc_hyst_t          O_POS_HYST0,
  output dcc_pkg::dcc_hyst_t          O_NEG_HYST0,
  output dcc_pkg::dcc_hyst_t          O_POS_HYST1,
  output dcc_pkg::dcc_hyst_t          O_NEG_HYST1,
  output logic      [1:0]             O_ENABLE,
  output logic                        O_IRQ,
  output logic                        O_RST_REQ
);
  import dcc_pkg::*;

  dcc_ctrl_s  ctrl [2];
  logic [3:0] irq_mask;
  logic       rst_src_en;
  logic [1:0] level;
  logic [1:0] rise_flag;
  logic [1:0] fall_flag;
  logic [1:0] settled;
  logic [1:0] clr_rise;
  logic [1:0] clr_fall;
  logic [1:0] wr_ctrl;
  logic [3:0] status;
  logic [7:0] next_rdata;

  // address decode helper for control registers
  function automatic logic [1:0] ctrl_hit(input logic [7:0] a);
    ctrl_hit = 2'b00;
    if (a == `DCC_CTRL0_ADDR)
      ctrl_hit = 2'b01;
    else if (a == `DCC_CTRL1_ADDR)
      ctrl_hit = 2'b10;
  endfunction

  assign wr_ctrl = I_WR ? ctrl_hit(I_ADDR) : 2'b00;

  // one control register and edge unit per comparator
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_cmp
      // writing zero to a flag clears it, one leaves it
      assign clr_rise[g] = wr_ctrl[g] & ~I_WDATA[`DCC_BIT_RISE];
      assign clr_fall[g] = wr_ctrl[g] & ~I_WDATA[`DCC_BIT_FALL];

      // enable and hysteresis fields
      always_ff @(posedge I_CLK)
      begin
        if (I_SRST)
        begin
          ctrl[g].enable       <= 1'b0;
          ctrl[g].rise_flag    <= 1'b0; // flags live in the edge unit
          ctrl[g].fall_flag    <= 1'b0;
          ctrl[g].pos_hyst_sel <= 2'h0;
          ctrl[g].neg_hyst_sel <= 2'h0;
        end
        else if (wr_ctrl[g])
        begin
          ctrl[g].enable       <= I_WDATA[`DCC_BIT_EN];
          ctrl[g].pos_hyst_sel <= I_WDATA[`DCC_POS_HI:`DCC_POS_LO];
          ctrl[g].neg_hyst_sel <= I_WDATA[`DCC_NEG_HI:`DCC_NEG_LO];
        end
      end

      dcc_edge_unit #(
        .SETTLE_CYC (SETTLE_CYC)
      ) u_edge (
        .i_clk       (I_CLK),
        .i_srst      (I_SRST),
        .i_raw       (I_CMP_RAW[g]),
        .i_enable    (ctrl[g].enable),
        .i_clr_rise  (clr_rise[g]),
        .i_clr_fall  (clr_fall[g]),
        .o_level     (level[g]),
        .o_rise_flag (rise_flag[g]),
        .o_fall_flag (fall_flag[g]),
        .o_settled   (settled[g])
      );
    end
  endgenerate

  // mask register and comparator 0 reset select
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      irq_mask   <= 4'h0;
      rst_src_en <= 1'b0;
    end
    else if (I_WR && I_ADDR == `DCC_IRQ_MASK_ADDR)
      irq_mask <= I_WDATA[3:0];
    else if (I_WR && I_ADDR == `DCC_RST_CFG_ADDR)
      rst_src_en <= I_WDATA[0];
  end

  // status layout: fall1 rise1 fall0 rise0, silent while off
  assign status = {fall_flag[1] & ctrl[1].enable,
                   rise_flag[1] & ctrl[1].enable,
                   fall_flag[0] & ctrl[0].enable,
                   rise_flag[0] & ctrl[0].enable};

  // read mux, unmapped reads return zero
  always_comb
  begin
    next_rdata = 8'h00;
    if (I_RD && ctrl_hit(I_ADDR) != 2'b00)
    begin
      for (int k = 0; k < 2; k++)
      begin
        if (ctrl_hit(I_ADDR) == 2'(1 << k))
        begin
          next_rdata = {ctrl[k].enable, level[k], rise_flag[k],
                        fall_flag[k], ctrl[k].pos_hyst_sel,
                        ctrl[k].neg_hyst_sel};
        end
      end
    end
    else if (I_RD && I_ADDR == `DCC_IRQ_MASK_ADDR)
      next_rdata = {4'h0, irq_mask};
    else if (I_RD && I_ADDR == `DCC_RST_CFG_ADDR)
      next_rdata = {7'h00, rst_src_en};
  end

  // read data register, valid the cycle after the strobe
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
      O_RDATA <= 8'h00;
    else
      O_RDATA <= next_rdata;
  end

  // registered outputs to pins and analog trims
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      O_CMP_PIN   <= 2'b00;
      O_SETTLED   <= 2'b00;
      O_ENABLE    <= 2'b00;
      O_POS_HYST0 <= 2'h0;
      O_NEG_HYST0 <= 2'h0;
      O_POS_HYST1 <= 2'h0;
      O_NEG_HYST1 <= 2'h0;
    end
    else
    begin
      O_CMP_PIN   <= level;
      O_SETTLED   <= settled;
      O_ENABLE    <= {ctrl[1].enable, ctrl[0].enable};
      O_POS_HYST0 <= ctrl[0].pos_hyst_sel;
      O_NEG_HYST0 <= ctrl[0].neg_hyst_sel;
      O_POS_HYST1 <= ctrl[1].pos_hyst_sel;
      O_NEG_HYST1 <= ctrl[1].neg_hyst_sel;
    end
  end

  // interrupt and reset requests
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      O_IRQ     <= 1'b0;
      O_RST_REQ <= 1'b0;
    end
    else
    begin
      O_IRQ     <= |(status & irq_mask);
      O_RST_REQ <= rst_src_en & ctrl[0].enable & level[0];
    end
  end
endmodule

/* core/dcc_defines.svh */
// register offsets, field positions, reset values and timing counts
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH
`define DCC_ADDR_W        8
`define DCC_CTRL0_ADDR    8'h9e
`define DCC_CTRL1_ADDR    8'h9f
`define DCC_IRQ_MASK_ADDR 8'ha0
`define DCC_RST_CFG_ADDR  8'ha1
`define DCC_BIT_EN        7
`define DCC_BIT_OUT       6
`define DCC_BIT_RISE      5
`define DCC_BIT_FALL      4
`define DCC_POS_HI        3
`define DCC_POS_LO        2
`define DCC_NEG_HI        1
`define DCC_NEG_LO        0
`define DCC_CTRL_RESET    8'h00
`define DCC_MASK_RESET    8'h00
`define DCC_SETTLE_NS     20000
`define DCC_CLK_PERIOD_NS 40
`define DCC_SETTLE_CYC    ((`DCC_SETTLE_NS + `DCC_CLK_PERIOD_NS - 1) / `DCC_CLK_PERIOD_NS)
`endif

/* core/dcc_pkg.sv */
// types shared by the comparator control block
package dcc_pkg;
  typedef logic [1:0] dcc_hyst_t;
  typedef struct packed {
    logic      enable;
    logic      rise_flag;
    logic      fall_flag;
    dcc_hyst_t pos_hyst_sel;
    dcc_hyst_t neg_hyst_sel;
  } dcc_ctrl_s;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dcc_bus_s;
endpackage

/* core/dcc_edge_unit.sv */
// per-comparator synchroniser, edge detection, flags and settling count
`timescale 1ns/100ps
`include "dcc_defines.svh"
module dcc_edge_unit
  import dcc_pkg::*;
#(
  parameter int SETTLE_CYC = `DCC_SETTLE_CYC
)(
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_raw,
  input  wire logic i_enable,
  input  wire logic i_clr_rise,
  input  wire logic i_clr_fall,
  output logic      o_level,
  output logic      o_rise_flag,
  output logic      o_fall_flag,
  output logic      o_settled
);
  localparam int CW = $clog2(SETTLE_CYC + 1);
  logic          sync_a;
  logic          sync_b;
  logic          prev;
  logic [CW-1:0] settle_cnt;
  logic          rise_evt;
  logic          fall_evt;

  // two-flop synchroniser for the analog comparator result
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end
    else
    begin
      sync_a <= i_raw;
      sync_b <= sync_a;
    end
  end

  // disabled comparator reads low
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      prev <= 1'b0;
    else
      prev <= i_enable & sync_b;
  end

  assign o_level  = prev;
  // edges only while enabled
  assign rise_evt = i_enable & sync_b & ~prev;
  assign fall_evt = i_enable & ~sync_b & prev;

  // sticky flags, set wins over clear
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_rise_flag <= 1'b0;
      o_fall_flag <= 1'b0;
    end
    else
    begin
      o_rise_flag <= rise_evt | (o_rise_flag & ~i_clr_rise);
      o_fall_flag <= fall_evt | (o_fall_flag & ~i_clr_fall);
    end
  end

  // settling counter restarts on each enable
  always_ff @(posedge i_clk)
  begin
    if (i_srst || !i_enable)
    begin
      settle_cnt <= '0;
      o_settled  <= 1'b0;
    end
    else if (settle_cnt != CW'(SETTLE_CYC))
    begin
      settle_cnt <= settle_cnt + CW'(1);
      o_settled  <= 1'b0;
    end
    else
      o_settled <= 1'b1;
  end
endmodule

/* verif/dcc_ana_src.sv */
// analog side: comparator input levels in millivolts
`timescale 1ns/100ps
module dcc_ana_src
(
  input  wire logic [1:0][11:0] i_plus,
  input  wire logic [1:0][11:0] i_minus,
  output logic      [1:0]       o_raw
);
  // raw decision lags the inputs, unrelated to the clock phase
  assign #13 o_raw = {i_plus[1] > i_minus[1], i_plus[0] > i_minus[0]};
endmodule

/* verif/dcc_top_asserts.sv */
// port checker for the comparator control top
`timescale 1ns/100ps
`include "dcc_defines.svh"
module dcc_top_chk
  import dcc_pkg::*;
#(
  parameter int SETTLE_CYC = 8
)(
  input wire logic                   I_CLK,
  input wire logic                   I_SRST,
  input wire logic [`DCC_ADDR_W-1:0] I_ADDR,
  input wire logic [7:0]             I_WDATA,
  input wire logic                   I_WR,
  input wire logic                   I_RD,
  input wire logic [7:0]             O_RDATA,
  input wire logic [1:0]             O_CMP_PIN,
  input wire logic [1:0]             O_SETTLED,
  input wire dcc_pkg::dcc_hyst_t     O_POS_HYST0,
  input wire dcc_pkg::dcc_hyst_t     O_NEG_HYST0,
  input wire logic [1:0]             O_ENABLE,
  input wire logic                   O_IRQ,
  input wire logic                   O_RST_REQ
);
  import dcc_pkg::*;
  localparam int SHI = SETTLE_CYC + 4;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  // a unit that has stayed off for three cycles
  sequence off0;
    (!O_ENABLE[0])[*3];
  endsequence
  sequence off1;
    (!O_ENABLE[1])[*3];
  endsequence
  pin_off0_a: assert property (off0 |-> !O_CMP_PIN[0])
    else $error("pin0 high while off");
  pin_off1_a: assert property (off1 |-> !O_CMP_PIN[1])
    else $error("pin1 high while off");
  irq_off_a: assert property (off0 and off1 |-> !O_IRQ)
    else $error("irq while both off");
  settle_off_a: assert property (off0 |-> !O_SETTLED[0])
    else $error("settled while off");
  settle_due_a: assert property ($rose(O_ENABLE[0]) |->
    ##[1:SHI] (O_SETTLED[0] || !O_ENABLE[0]))
    else $error("settle late");
  rst_src_a: assert property (O_RST_REQ |-> O_ENABLE[0])
    else $error("reset request while off");
  hyst_src_a: assert property ($changed({O_POS_HYST0, O_NEG_HYST0}) |->
    $past(I_WR, 2) && $past(I_ADDR, 2) == `DCC_CTRL0_ADDR)
    else $error("hysteresis moved without write");
  en_set_a: assert property ($past(I_WR, 2) &&
    $past(I_ADDR, 2) == `DCC_CTRL0_ADDR |-> O_ENABLE[0] == $past(I_WDATA[7], 2))
    else $error("enable not written");
  rd_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data outside read");
endmodule
bind dcc_top dcc_top_chk #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.*);

/* verif/dcc_top_tb_top.sv */
// self-checking bench for the comparator control block
`timescale 1ns/100ps
`include "dcc_defines.svh"
module dcc_top_tb_top;
  import dcc_pkg::*;
  logic             clk = 0, srst = 1, wr = 0, rd = 0, irq, rstq;
  logic [7:0]       addr = 0, wdata = 0, rdata;
  logic [1:0][11:0] vp = 0, vm = 0;
  logic [1:0]       raw, pin, stl, en;
  dcc_hyst_t        ph0, nh0, ph1, nh1;
  int               num_errors = 0, n_checks = 0;
  // analog source and design
  dcc_ana_src u_ana (.i_plus(vp), .i_minus(vm), .o_raw(raw));
  dcc_top #(.SETTLE_CYC(8)) u_dut (.I_CLK(clk), .I_SRST(srst),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .I_CMP_RAW(raw), .O_RDATA(rdata), .O_CMP_PIN(pin), .O_SETTLED(stl),
    .O_POS_HYST0(ph0), .O_NEG_HYST0(nh0), .O_POS_HYST1(ph1),
    .O_NEG_HYST1(nh1), .O_ENABLE(en), .O_IRQ(irq), .O_RST_REQ(rstq));
  // 25 MHz clock
  initial forever #20 clk = ~clk;
  // compare one value
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // wait n edges, then step past the edge
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrr(logic [7:0] a, logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rdr(logic [7:0] a, logic [7:0] e, string nm);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask
  // bounded wait for the settle flag
  task automatic wait_stl(int n);
    int k;
    for (k = 0; k < 40 && stl[n] !== 1'b1; k++)
      cyc(1);
    if (k == 40)
    begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic t_regs();
    rdr(`DCC_CTRL0_ADDR, `DCC_CTRL_RESET, "ctrl0");
    rdr(`DCC_CTRL1_ADDR, `DCC_CTRL_RESET, "ctrl1");
    rdr(`DCC_IRQ_MASK_ADDR, `DCC_MASK_RESET, "mask");
    rdr(8'hb5, 8'h00, "unmapped");
    $display("test regs done");
  endtask
  // every hysteresis code, read-only status bit written as one
  task automatic t_hyst(int n);
    logic [3:0] v;
    for (int c = 0; c < 4; c++)
    begin
      v = {c[1:0], 2'(3 - c)};
      wrr(8'(`DCC_CTRL0_ADDR + n), {4'h4, v});
      cyc(1);
      chk("hyst", {4'h0, v}, n ? {ph1, nh1} : {ph0, nh0});
      rdr(8'(`DCC_CTRL0_ADDR + n), {4'h0, v}, "ctrl");
    end
    $display("test hyst done");
  endtask
  // edges, sticky flags, mask and interrupt level
  task automatic t_edge(int n);
    logic [7:0] a;
    a = 8'(`DCC_CTRL0_ADDR + n);
    vm[n] = 12'd500;
    vp[n] = 12'd400;
    wrr(a, 8'h80);
    wait_stl(n);
    chk("enable", 8'h01, en[n]);
    wrr(a, 8'h80);
    wrr(`DCC_IRQ_MASK_ADDR, 8'(3 << 2 * n));
    vp[n] = 12'd600;
    cyc(6);
    chk("pin", 8'h01, pin[n]);
    rdr(a, 8'he0, "rise");
    vp[n] = 12'd400;
    cyc(6);
    chk("pin", 8'h00, pin[n]);
    rdr(a, 8'hb0, "both");
    wrr(`DCC_IRQ_MASK_ADDR, 8'h00);
    cyc(2);
    chk("masked", 8'h00, irq);
    wrr(`DCC_IRQ_MASK_ADDR, 8'(3 << 2 * n));
    cyc(2);
    chk("irq", 8'h01, irq);
    wrr(a, 8'h90);
    rdr(a, 8'h90, "clr rise");
    chk("irq", 8'h01, irq);
    wrr(a, 8'h80);
    cyc(2);
    chk("irq", 8'h00, irq);
    $display("test edge done");
  endtask
  // disabling forces pin low and stops flags
  task automatic t_off();
    wrr(`DCC_IRQ_MASK_ADDR, 8'h0f);
    vp[0] = 12'd600;
    cyc(6);
    wrr(`DCC_CTRL0_ADDR, 8'h30);
    vp[0] = 12'd400;
    cyc(6);
    chk("pin off", 8'h00, pin[0]);
    chk("irq off", 8'h00, irq);
    rdr(`DCC_CTRL0_ADDR, 8'h20, "off");
    $display("test off done");
  endtask
  // only comparator 0 drives the reset request
  task automatic t_rst();
    wrr(`DCC_RST_CFG_ADDR, 8'h01);
    wrr(`DCC_CTRL0_ADDR, 8'h80);
    vp[1] = 12'd600;
    cyc(6);
    chk("rst cmp1", 8'h00, rstq);
    vp[0] = 12'd600;
    cyc(6);
    chk("rst cmp0", 8'h01, rstq);
    wrr(`DCC_RST_CFG_ADDR, 8'h00);
    cyc(2);
    chk("rst off", 8'h00, rstq);
    $display("test rst done");
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    cyc(1);
    t_regs();
    t_hyst(0);
    t_hyst(1);
    t_edge(0);
    t_edge(1);
    t_off();
    t_rst();
    conclude();
  end
endmodule
